// file: src/swtef_flags.sv
`timescale 1ns/1ns
// What this block does
// - in compatible mode the address-detect flag (bit 12) is 1 when the receive data buffer word is an address, else 0.
// - the address-detect flag clears on module reset bit, software reset, system reset, or a received data frame.
// - in compatible mode transmit-empty (bit 11) is 1 only when buffer and shifter are both empty.
// - in LIN multibuffer mode transmit-empty is 1 only when all multibuffer words and the shifter are empty.
// - in LIN mode without multibuffering the empty state comes from the single-byte transmit register plus the shifter.
// - module reset bit, software reset and system reset force transmit-empty to 1.
// - transmit-empty never raises an interrupt request.
module swtef_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_word_done,
  input wire logic rx_word_is_addr,
  input wire logic txbuf_full,
  input wire logic single_byte_transmit_register_full,
  input wire logic [swtef_pkg::MBUF_WORDS-1:0] mbuf_full,
  input wire logic shift_full,
  output logic address_detect_flag,
  output logic tx_empty_flag
);
  import swtef_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] ctrl_q, ctrl_d;
  logic addr_q, addr_d;
  logic txe_q, txe_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic rdy_q, rdy_d;
  logic txe_raw;
  logic hold_reset;
  logic [1:0] mode;
  logic setup;

  // valid address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == FLAGS_ADDR) || (a == CTRL_ADDR) || (a == STATUS_ADDR);
  endfunction

  // module reset bit high or software reset low holds flags at reset
  assign hold_reset = ctrl_q[CTRL_MODULE_RESET_BIT] ||
    !ctrl_q[CTRL_SW_RESET_N_BIT];

  // mode decode from control bits
  always_comb begin
    if (!ctrl_q[CTRL_LIN_MODE_BIT]) begin
      mode = SWTEF_COMPAT;
    end else if (ctrl_q[CTRL_MBUF_BIT]) begin
      mode = SWTEF_LIN_MBUF;
    end else begin
      mode = SWTEF_LIN_SINGLE;
    end
  end

  swtef_tx_empty u_txe (
    .mode(mode),
    .txbuf_full(txbuf_full),
    .single_byte_transmit_register_full(single_byte_transmit_register_full),
    .mbuf_full(mbuf_full),
    .shift_full(shift_full),
    .tx_empty(txe_raw)
  );

  // ****************************************************************
  // flag next state
  // ****************************************************************
  // flags change only from hardware events and control-word writes, never from writes to the flags word
  always_comb begin
    addr_d = addr_q;
    txe_d = txe_raw;
    if (hold_reset) begin
      addr_d = 1'b0;
      txe_d = 1'b1;
    end else if (mode != SWTEF_COMPAT) begin
      addr_d = 1'b0;
    end else if (rx_word_done) begin
      addr_d = rx_word_is_addr;
    end
  end

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  assign setup = psel && !penable;

  // answer is prepared in setup so access phase completes at once
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    err_d = 1'b0;
    rdy_d = setup;
    if (setup) begin
      err_d = !mapped(paddr);
      rdata_d = ZERO_WORD;
      if (!pwrite) begin
        unique case (paddr)
          FLAGS_ADDR: begin
            rdata_d[ADDR_DETECT_BIT] = addr_q;
            rdata_d[TX_EMPTY_BIT] = txe_q;
          end
          CTRL_ADDR: rdata_d = ctrl_q;
          STATUS_ADDR: begin
            rdata_d[STAT_TXBUF_BIT] = txbuf_full;
            rdata_d[STAT_SHIFT_BIT] = shift_full;
            rdata_d[STAT_MBUF_BIT] = |mbuf_full;
            rdata_d[STAT_SINGLE_BYTE_TRANSMIT_REGISTER_BIT] = single_byte_transmit_register_full;
          end
          default: rdata_d = ZERO_WORD;
        endcase
      end
    end
    // writes land at the access edge; flags word is ignored
    if (psel && penable && pready && pwrite && paddr == CTRL_ADDR) begin
      ctrl_d = pwdata;
    end
  end

  // registers: system reset forces flags to their reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= 1'b0;
      txe_q <= 1'b1;
      rdata_q <= ZERO_WORD;
      err_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      txe_q <= txe_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      rdy_q <= rdy_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign address_detect_flag = addr_q;
  // no interrupt path exists for the empty flag
  assign tx_empty_flag = txe_q;
endmodule

// file: src/swtef_pkg.sv
package swtef_pkg;
  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] FLAGS_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ADDR_DETECT_BIT = 12;
  localparam int TX_EMPTY_BIT = 11;
  localparam int CTRL_MODULE_RESET_BIT = 0;
  localparam int CTRL_SW_RESET_N_BIT = 7;
  localparam int CTRL_LIN_MODE_BIT = 6;
  localparam int CTRL_MBUF_BIT = 10;
  localparam int STAT_TXBUF_BIT = 0;
  localparam int STAT_SHIFT_BIT = 1;
  localparam int STAT_MBUF_BIT = 2;
  localparam int STAT_SINGLE_BYTE_TRANSMIT_REGISTER_BIT = 3;

  // ****************************************************************
  // reset values and sizes
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int MBUF_WORDS = 8;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // operating mode seen by the empty-flag logic
  typedef enum logic [1:0] {
    SWTEF_COMPAT,
    SWTEF_LIN_SINGLE,
    SWTEF_LIN_MBUF
  } swtef_mode_t;
endpackage

// file: src/swtef_tx_empty.sv
`timescale 1ns/1ns
module swtef_tx_empty (
  input wire logic [1:0] mode,
  input wire logic txbuf_full,
  input wire logic single_byte_transmit_register_full,
  input wire logic [7:0] mbuf_full,
  input wire logic shift_full,
  output logic tx_empty
);
  import swtef_pkg::*;

  // ****************************************************************
  // transmit-empty derivation per mode
  // ****************************************************************
  // pick the buffer source by mode, then merge with the shifter
  always_comb begin
    unique case (swtef_mode_t'(mode))
      SWTEF_COMPAT: tx_empty = !txbuf_full && !shift_full;
      SWTEF_LIN_SINGLE: tx_empty = !single_byte_transmit_register_full && !shift_full;
      SWTEF_LIN_MBUF: tx_empty = !(|mbuf_full) && !shift_full;
      default: tx_empty = !txbuf_full && !shift_full;
    endcase
  end
endmodule

// file: test/swtef_flags_properties.sv
`timescale 1ns/1ns
module swtef_flags_properties
  import swtef_pkg::*;
(
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready, rx_word_done, rx_word_is_addr,
  input wire logic txbuf_full, single_byte_transmit_register_full, shift_full,
  input wire logic [MBUF_WORDS-1:0] mbuf_full,
  input wire logic address_detect_flag, tx_empty_flag
);
  logic [31:0] ctrl_q, ctrl_d;
  // shadow of the control word, since the mode is not a port
  always_comb begin
    ctrl_d = ctrl_q;
    if (psel && penable && pwrite && pready && paddr == CTRL_ADDR) begin
      ctrl_d = pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RESET;
    else ctrl_q <= ctrl_d;
  end
  wire run = ctrl_q[CTRL_SW_RESET_N_BIT] & !ctrl_q[CTRL_MODULE_RESET_BIT];
  wire lin = ctrl_q[CTRL_LIN_MODE_BIT];
  wire mb = lin & ctrl_q[CTRL_MBUF_BIT];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  hold_empty_a: assert property (!run |=> tx_empty_flag)
    else $error("empty flag not forced");
  compat_empty_a: assert property (run && !lin |=>
    tx_empty_flag != $past(txbuf_full | shift_full)) else $error("compat");
  single_empty_a: assert property (run && lin && !mb |=>
    tx_empty_flag != $past(single_byte_transmit_register_full | shift_full)) else $error("single");
  mbuf_empty_a: assert property (run && mb |=>
    tx_empty_flag != $past(|mbuf_full | shift_full)) else $error("mbuf");
  addr_set_a: assert property (run && !lin && rx_word_done |=>
    address_detect_flag == $past(rx_word_is_addr)) else $error("addr set");
  addr_clear_a: assert property (!run || lin || rx_word_done &&
    !rx_word_is_addr |=> !address_detect_flag) else $error("addr clear");
  addr_hold_a: assert property (run && !lin && !rx_word_done |=>
    $stable(address_detect_flag)) else $error("addr changed");
  ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready");
endmodule
bind swtef_flags swtef_flags_properties i_props (.*);

// file: test/swtef_peer.sv
`timescale 1ns/1ns
module swtef_peer (
  input wire logic pclk,
  output logic rx_word_done = 1'b0,
  output logic rx_word_is_addr = 1'b0,
  output logic txbuf_full = 1'b0,
  output logic single_byte_transmit_register_full = 1'b0,
  output logic shift_full = 1'b0,
  output logic [7:0] mbuf_full = 8'h00
);
  // a received word; the kind line flips after, it is not held
  task automatic word(input logic a);
    @(posedge pclk);
    rx_word_done <= 1'b1;
    rx_word_is_addr <= a;
    @(posedge pclk);
    rx_word_done <= 1'b0;
    rx_word_is_addr <= !a;
  endtask
  // fill state of the transmit path
  task automatic fill(input logic t, l, s, input logic [7:0] m);
    @(posedge pclk);
    txbuf_full <= t;
    single_byte_transmit_register_full <= l;
    shift_full <= s;
    mbuf_full <= m;
    @(posedge pclk);
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import swtef_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, s, rx_word_done, rx_word_is_addr, txbuf_full;
  logic single_byte_transmit_register_full, shift_full, address_detect_flag, tx_empty_flag;
  logic [MBUF_WORDS-1:0] mbuf_full;
  int n_mismatch = 0, samples_checked = 0;
  swtef_flags i_swtef_flags (.*);
  swtef_peer i_swtef_peer (.*);
  initial forever #10 pclk = ~pclk;
  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, idle cycle after so strobes never double up
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // a lost answer ends the run here, nothing runs after the verdict
    if (n >= 16) begin
      n_mismatch++;
      end_of_test();
    end else begin
      r = prdata;
      s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // whole flags word, so stray bits outside 12 and 11 are caught too
  task automatic flags(input logic [1:0] e);
    logic [31:0] w;
    w = ZERO_WORD;
    w[ADDR_DETECT_BIT] = e[1];
    w[TX_EMPTY_BIT] = e[0];
    apb(0, FLAGS_ADDR, 0);
    cmp("flags", w, r);
    cmp("addr_pin", {31'h0, e[1]}, {31'h0, address_detect_flag});
    cmp("empty_pin", {31'h0, e[0]}, {31'h0, tx_empty_flag});
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    flags(2'b01);
    i_swtef_peer.fill(1, 0, 1, 8'h00);
    flags(2'b01);
    apb(0, STATUS_ADDR, 0);
    cmp("status", 32'h0000_0003, r);
    apb(1, CTRL_ADDR, 32'h80);
    flags(2'b00);
    i_swtef_peer.fill(0, 0, 0, 8'h00);
    flags(2'b01);
    i_swtef_peer.word(1);
    flags(2'b11);
    apb(1, FLAGS_ADDR, 32'h0);
    flags(2'b11);
    i_swtef_peer.word(0);
    flags(2'b01);
    i_swtef_peer.word(1);
    i_swtef_peer.fill(1, 0, 0, 8'h00);
    apb(1, CTRL_ADDR, 32'h81);
    flags(2'b01);
    apb(1, CTRL_ADDR, 32'hc0);
    flags(2'b01);
    i_swtef_peer.fill(0, 1, 0, 8'h00);
    flags(2'b00);
    apb(1, FLAGS_ADDR, 32'h0000_1800);
    flags(2'b00);
    apb(1, CTRL_ADDR, 32'h4c0);
    apb(0, CTRL_ADDR, 0);
    cmp("ctrl", 32'h0000_04c0, r);
    flags(2'b01);
    i_swtef_peer.fill(0, 0, 0, 8'h80);
    flags(2'b00);
    apb(0, 8'h0c, 0);
    cmp("slverr", 1, {31'h0, s});
    end_of_test();
  end
endmodule
